/* File: servo_node_cyclic_status.sv */
// Operation
// RQ1: Identifier word carries both selectors, top digits.
// RQ2: Software re-reads identifier after selector change.
// RQ3: Link indicator follows port link state.
// RQ4: Repeater indicator pattern follows network state.
// RQ5: Receive indicator pattern follows network state.
// RQ6: Indicators depend only on network logic.
// RQ7: Before joining, only servo-off segment lit.
// RQ8: Alarm digits and overtravel shown alternately.
// RQ9: Torque demand accepted every cycle, 10000 full.
// RQ10: Amplifier enable demand steers servo enable.
// RQ11: Every response field refreshed each cycle.
// RQ12: Drive-ready gates the conditional status flags.
// RQ13: Encoder and power flags follow their sources.
// RQ14: Servo-on clear when PWM off or braking.
// RQ15: Torque-limit flag when reference exceeds limit.
// RQ16: Fault flag set on shutdown; cause via memory.
// RQ17: Position, torque echo, multi-turn returned each cycle.
// RQ18: Multi-turn data is sixteen bits.
// RQ19: Clear-alarm removes clearable alarms, may clear fault.
// RQ20: Alarm and warning read, count, clear commands.
// RQ21: Multi-turn clear resets turns and backup alarm.
// RQ22: Requests are direct commands or memory operations.
// RQ23: Controller sends one request per cycle.
// RQ24: New demand applied on the cyclic strobe.
// RQ25: Timing derives from the 25 MHz clock.
// RQ26: Blinks are half-duty divisions of the clock.
// RQ27: Unsupported command leaves state unchanged.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module servo_node_cyclic_status #(
  parameter int ALARMS    = 4,
  parameter int HALF_SLOW = servo_node_pkg::HALF_SLOW,
  parameter int HALF_MID  = servo_node_pkg::HALF_MID,
  parameter int HALF_FAST = servo_node_pkg::HALF_FAST,
  parameter int ALT_CYC   = servo_node_pkg::ALT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  first_rotary_selector,
  input  wire logic [3:0]  second_rotary_selector,
  input  wire logic [1:0]  link_up,
  input  wire logic [2:0]  net_state,
  input  wire logic        repeater_on,
  input  wire logic        cyclic_strobe,
  input  wire logic [15:0] torque_demand,
  input  wire logic        amp_enable_demand,
  input  wire logic        comm_active,
  input  wire logic        encoder_sync_ok,
  input  wire logic        motor_voltage_ok,
  input  wire logic        pwm_off,
  input  wire logic        dynamic_brake,
  input  wire logic        hw_enable,
  input  wire logic [15:0] torque_reference,
  input  wire logic [31:0] position_in,
  input  wire logic [15:0] multiturn_in,
  input  wire logic        alarm_event,
  input  wire logic [15:0] alarm_code,
  input  wire logic        alarm_clearable,
  input  wire logic        warning_event,
  input  wire logic [15:0] warning_code,
  input  wire logic        forward_overtravel,
  input  wire logic        reverse_overtravel,
  output logic      [1:0]  link_indicator,
  output logic             repeater_indicator,
  output logic             receive_indicator,
  output logic      [6:0]  segment,
  output logic      [15:0] torque_command,
  output logic             servo_enable,
  output logic             fault_line,
  output logic             multiturn_clear,
  output logic      [6:0]  resp_status,
  output logic      [31:0] resp_position,
  output logic      [15:0] resp_torque_echo,
  output logic      [15:0] resp_multiturn
);
  localparam int PW = $clog2(ALARMS);

  // Counters are 26 bits wide, so longer periods cannot be served.
  if (ALARMS < 2 || (ALARMS & (ALARMS - 1)) != 0 || HALF_SLOW < 1 || HALF_SLOW >= 2**26 ||
      HALF_MID < 1 || HALF_MID >= 2**26 || HALF_FAST < 1 || HALF_FAST >= 2**26 ||
      ALT_CYC < 1 || ALT_CYC >= 2**26) begin : g_bad
    $error("servo_node_cyclic_status: parameter out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered.
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_mux;
  logic [31:0] id_word;
  logic [31:0] svc_result;
  logic [15:0] torque_limit;
  assign acc   = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign hit   = paddr inside {servo_node_pkg::ADDR_ID, servo_node_pkg::ADDR_SVC, servo_node_pkg::ADDR_RES,
                               servo_node_pkg::ADDR_STAT, servo_node_pkg::ADDR_TLIM, servo_node_pkg::ADDR_POS,
                               servo_node_pkg::ADDR_ECHO};
  // Selectors are read live, so a changed switch shows on the next read.
  assign id_word = {first_rotary_selector, second_rotary_selector, 24'h00_0000}; // RQ1
  assign rd_mux  = (paddr == servo_node_pkg::ADDR_ID)   ? id_word :
                   (paddr == servo_node_pkg::ADDR_RES)  ? svc_result :
                   (paddr == servo_node_pkg::ADDR_STAT) ? {25'h000_0000, resp_status} :
                   (paddr == servo_node_pkg::ADDR_TLIM) ? {16'h0000, torque_limit} :
                   (paddr == servo_node_pkg::ADDR_POS)  ? resp_position :
                   (paddr == servo_node_pkg::ADDR_ECHO) ? {resp_multiturn, resp_torque_echo} : 32'h0000_0000;

  // Read data and error are captured in the cycle before pready rises.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Service request decode; a write to the command register starts one.
  logic       svc_go;
  logic       is_direct;
  logic       rw;
  logic [3:0] op;
  logic [7:0] arg;
  logic       clr_alarm;
  logic       clr_warn;
  logic       mt_clr;
  logic       supported;
  assign svc_go    = wr_en & (paddr == servo_node_pkg::ADDR_SVC);
  assign is_direct = pwdata[servo_node_pkg::SVC_DIR_BIT]; // RQ22
  assign rw        = pwdata[servo_node_pkg::SVC_RW_BIT];
  assign op        = pwdata[servo_node_pkg::SVC_OP_LSB +: 4];
  assign arg       = pwdata[7:0];
  assign supported = is_direct ?
    ((op == servo_node_pkg::OP_READ_ALARM  && !rw) || (op == servo_node_pkg::OP_ALARM_COUNT && !rw) ||
     (op == servo_node_pkg::OP_CLEAR_ALARM &&  rw) || (op == servo_node_pkg::OP_READ_WARN) ||
     (op == servo_node_pkg::OP_WARN_COUNT  && !rw) || (op == servo_node_pkg::OP_CLEAR_WARN  && rw) ||
     (op == servo_node_pkg::OP_MT_READ) || (op == servo_node_pkg::OP_MT_CLEAR && rw)) :
    (pwdata[servo_node_pkg::SVC_MEM_LSB +: 2] == servo_node_pkg::MEM_ERROR_CODE && !rw);
  // State-changing commands fire only when fully supported.
  assign clr_alarm = svc_go & is_direct & supported & (op == servo_node_pkg::OP_CLEAR_ALARM); // RQ27
  assign clr_warn  = svc_go & is_direct & supported & (op == servo_node_pkg::OP_CLEAR_WARN); // RQ27
  assign mt_clr    = svc_go & is_direct & supported & (op == servo_node_pkg::OP_MT_CLEAR); // RQ27

  //////////////////////////////////////////////////////////////////////////////
  // Alarm and warning lists; a new event beats a clear in the same cycle.
  logic [ALARMS-1:0] alm_valid;
  logic [ALARMS-1:0] alm_clr;
  logic [ALARMS-1:0] wrn_valid;
  logic [15:0]       alm_code [ALARMS];
  logic [15:0]       wrn_code [ALARMS];
  logic [PW-1:0]     alm_ptr;
  logic [PW-1:0]     wrn_ptr;
  logic [PW-1:0]     last_alm;
  logic [15:0]       fault_code;
  for (genvar i = 0; i < ALARMS; i++) begin : g_list
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        alm_valid[i] <= 1'b0;
        alm_clr[i]   <= 1'b0;
        alm_code[i]  <= 16'h0000;
        wrn_valid[i] <= 1'b0;
        wrn_code[i]  <= 16'h0000;
      end else begin
        if (alarm_event && alm_ptr == PW'(i)) begin
          alm_valid[i] <= 1'b1;
          alm_clr[i]   <= alarm_clearable;
          alm_code[i]  <= alarm_code;
        end else if ((clr_alarm && alm_clr[i]) || (mt_clr && alm_code[i] == servo_node_pkg::ALARM_BACKUP)) begin
          alm_valid[i] <= 1'b0; // RQ19 RQ21
        end
        if (warning_event && wrn_ptr == PW'(i)) begin
          wrn_valid[i] <= 1'b1;
          wrn_code[i]  <= warning_code;
        end else if (clr_warn) begin
          wrn_valid[i] <= 1'b0; // RQ20
        end
      end
    end
  end

  // Pointers wrap, so the oldest entry is overwritten once the list is full.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alm_ptr    <= '0;
      wrn_ptr    <= '0;
      last_alm   <= '0;
      fault_code <= 16'h0000;
    end else begin
      if (alarm_event) begin
        alm_ptr    <= alm_ptr + 1'b1;
        last_alm   <= alm_ptr;
        fault_code <= alarm_code;
      end
      if (warning_event) wrn_ptr <= wrn_ptr + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault, servo enable, service results.
  logic        no_hard_left;
  logic        next_fault;
  logic        amp_en;
  logic [15:0] svc_data;
  logic [15:0] abs_ref;
  assign no_hard_left = ~|(alm_valid & ~alm_clr);
  assign next_fault   = alarm_event ? 1'b1 : (clr_alarm && no_hard_left) ? 1'b0 : fault_line; // RQ16 RQ19
  assign abs_ref      = torque_reference[15] ? 16'(-torque_reference) : torque_reference;
  assign svc_data = !is_direct ? fault_code : // RQ16
                    (op == servo_node_pkg::OP_READ_ALARM)  ? alm_code[arg[PW-1:0]] :
                    (op == servo_node_pkg::OP_ALARM_COUNT) ? 16'($countones(alm_valid)) :
                    (op == servo_node_pkg::OP_READ_WARN)   ? wrn_code[arg[PW-1:0]] :
                    (op == servo_node_pkg::OP_WARN_COUNT)  ? 16'($countones(wrn_valid)) :
                    (op == servo_node_pkg::OP_MT_READ)     ? multiturn_in : 16'h0000; // RQ18 RQ20

  // The enable drops at once on braking or PWM off; it returns only with every condition met.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_line      <= 1'b0;
      servo_enable    <= 1'b0;
      amp_en          <= 1'b0;
      torque_command  <= 16'h0000;
      torque_limit    <= servo_node_pkg::TORQUE_FULL;
      multiturn_clear <= 1'b0;
      svc_result      <= 32'h0000_0000;
    end else begin
      fault_line      <= next_fault;
      servo_enable    <= amp_en & hw_enable & ~next_fault & ~pwm_off & ~dynamic_brake; // RQ10 RQ14 RQ19
      multiturn_clear <= mt_clr; // RQ21
      if (cyclic_strobe) begin
        amp_en         <= amp_enable_demand; // RQ24 RQ10
        torque_command <= torque_demand; // RQ9
      end
      if (wr_en && paddr == servo_node_pkg::ADDR_TLIM) torque_limit <= pwdata[15:0];
      if (svc_go) svc_result <= {14'h0000, ~supported, 1'b1, supported ? svc_data : 16'h0000};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cyclic response buffer, refreshed on every strobe.
  logic       drive_ready;
  logic [6:0] next_status;
  assign drive_ready = comm_active;
  assign next_status = {fault_line, |wrn_valid,
                        drive_ready & (abs_ref > torque_limit), // RQ15
                        drive_ready & servo_enable, // RQ14
                        drive_ready & motor_voltage_ok, drive_ready & encoder_sync_ok, // RQ13
                        drive_ready}; // RQ12

  // The buffer only moves on the strobe, so a reader sees one coherent cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_status      <= 7'h00;
      resp_position    <= 32'h0000_0000;
      resp_torque_echo <= 16'h0000;
      resp_multiturn   <= 16'h0000;
    end else if (cyclic_strobe) begin
      resp_status      <= next_status; // RQ11
      resp_position    <= position_in; // RQ17
      resp_torque_echo <= torque_command; // RQ17
      resp_multiturn   <= multiturn_in; // RQ18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Blink generators: each toggles at its half period, giving half duty.
  localparam int HALF [3] = '{HALF_SLOW, HALF_MID, HALF_FAST};
  logic [2:0] blink;
  for (genvar b = 0; b < 3; b++) begin : g_blink
    logic [25:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt      <= 26'h000_0000;
        blink[b] <= 1'b0;
      end else if (cnt == 26'(HALF[b] - 1)) begin
        cnt      <= 26'h000_0000;
        blink[b] <= ~blink[b]; // RQ26 RQ25
      end else begin
        cnt <= cnt + 26'h000_0001;
      end
    end
  end

  // Indicators look only at link and network state, never at drive state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_indicator     <= 2'b00;
      repeater_indicator <= 1'b0;
      receive_indicator  <= 1'b0;
    end else begin
      link_indicator <= link_up; // RQ3 RQ6
      case (net_state)
        servo_node_pkg::NET_SYNQ: begin
          repeater_indicator <= repeater_on; // RQ4
          receive_indicator  <= 1'b1; // RQ5
        end
        servo_node_pkg::NET_DISC: begin
          repeater_indicator <= repeater_on & blink[1]; // RQ4
          receive_indicator  <= blink[1]; // RQ5
        end
        servo_node_pkg::NET_LOST: begin
          repeater_indicator <= repeater_on & blink[2]; // RQ4
          receive_indicator  <= blink[2]; // RQ5
        end
        servo_node_pkg::NET_UNDISC: begin
          repeater_indicator <= 1'b0;
          receive_indicator  <= blink[0]; // RQ5
        end
        default: begin
          repeater_indicator <= 1'b0;
          receive_indicator  <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Seven-segment display with a slow alternation phase.
  logic        joined;
  logic [25:0] alt_cnt;
  logic [1:0]  phase;
  logic [15:0] shown;
  logic [6:0]  next_segment;
  assign shown = alm_code[last_alm];
  assign next_segment =
    !joined ? servo_node_pkg::SEG_SERVO_OFF : // RQ7
    |alm_valid ? ((phase == 2'd0) ? servo_node_pkg::SEG_ALARM :
                  servo_node_pkg::SEG_HEX[shown[4*(3-phase) +: 4]]) : // RQ8
    forward_overtravel ? (phase[0] ? servo_node_pkg::SEG_FWD_OT : servo_node_pkg::SEG_BLANK) : // RQ8
    reverse_overtravel ? (phase[0] ? servo_node_pkg::SEG_REV_OT : servo_node_pkg::SEG_BLANK) : // RQ8
    servo_enable ? servo_node_pkg::SEG_SERVO_ON : servo_node_pkg::SEG_SERVO_OFF;

  // Joining is sticky: a later loss of sync keeps status shown, not the power-up face.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      joined  <= 1'b0;
      alt_cnt <= 26'h000_0000;
      phase   <= 2'd0;
      segment <= servo_node_pkg::SEG_BLANK;
    end else begin
      if (net_state == servo_node_pkg::NET_SYNQ) joined <= 1'b1;
      if (alt_cnt == 26'(ALT_CYC - 1)) begin
        alt_cnt <= 26'h000_0000;
        phase   <= phase + 2'd1;
      end else begin
        alt_cnt <= alt_cnt + 26'h000_0001;
      end
      segment <= next_segment;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the guarded behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_id_word; // RQ1
    acc && !pwrite && paddr == servo_node_pkg::ADDR_ID |=>
      prdata[31:24] == $past({first_rotary_selector, second_rotary_selector}) && pready;
  endproperty
  a_id_word: assert property (p_id_word) else $error("identifier word wrong");
  property p_link; // RQ3
    1'b1 |=> link_indicator == $past(link_up);
  endproperty
  a_link: assert property (p_link) else $error("link indicator not lit");
  property p_repeater_indicator_off; // RQ4
    net_state == servo_node_pkg::NET_INACTIVE |=> !repeater_indicator && !receive_indicator;
  endproperty
  a_repeater_indicator_off: assert property (p_repeater_indicator_off) else $error("port indicator lit while inactive");
  property p_rcv_synq; // RQ5
    net_state == servo_node_pkg::NET_SYNQ |=> receive_indicator;
  endproperty
  a_rcv_synq: assert property (p_rcv_synq) else $error("receive indicator not steady");
  property p_torque; // RQ9
    cyclic_strobe |=> torque_command == $past(torque_demand) && resp_torque_echo == $past(torque_command);
  endproperty
  a_torque: assert property (p_torque) else $error("torque demand not applied");
  property p_servo_off; // RQ14
    (pwm_off || dynamic_brake) |=> !servo_enable;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("servo enabled while braking");
  property p_clear; // RQ19
    clr_alarm && no_hard_left && !alarm_event |=> !fault_line;
  endproperty
  a_clear: assert property (p_clear) else $error("fault not cleared");
  property p_fault; // RQ16
    alarm_event |=> fault_line && !servo_enable;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not raised");
  property p_seg_off; // RQ7
    !joined && net_state != servo_node_pkg::NET_SYNQ |=> segment == servo_node_pkg::SEG_SERVO_OFF;
  endproperty
  a_seg_off: assert property (p_seg_off) else $error("display not servo-off before joining");
  property p_unsup; // RQ27
    svc_go && !supported && !alarm_event && !warning_event |=> $stable(alm_valid) && $stable(wrn_valid);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported command changed state");
endmodule : servo_node_cyclic_status
`default_nettype wire

/* File: servo_node_pkg.sv */
`default_nettype none
package servo_node_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] ADDR_ID   = 8'h00;
  localparam logic [7:0] ADDR_SVC  = 8'h04;
  localparam logic [7:0] ADDR_RES  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TLIM = 8'h10;
  localparam logic [7:0] ADDR_POS  = 8'h14;
  localparam logic [7:0] ADDR_ECHO = 8'h18;
  // Service command fields.
  localparam int SVC_OP_LSB  = 8;
  localparam int SVC_RW_BIT  = 12;
  localparam int SVC_DIR_BIT = 13;
  localparam int SVC_MEM_LSB = 14;
  localparam int RES_DONE_BIT = 16;
  localparam int RES_ERR_BIT  = 17;
  localparam int ID_SEL_LSB   = 24;
  typedef enum logic [3:0] {
    OP_READ_ALARM = 4'h0, OP_ALARM_COUNT = 4'h1, OP_CLEAR_ALARM = 4'h2, OP_READ_WARN = 4'h3,
    OP_WARN_COUNT = 4'h4, OP_CLEAR_WARN = 4'h5, OP_MT_READ = 4'h6, OP_MT_CLEAR = 4'h7
  } op_e;
  localparam logic [1:0] MEM_ERROR_CODE = 2'h0;
  typedef enum logic [2:0] {
    NET_INACTIVE = 3'h0, NET_UNDISC = 3'h1, NET_DISC = 3'h2, NET_SYNQ = 3'h3, NET_LOST = 3'h4
  } net_state_e;
  // Encoder backup alarm and torque scale.
  localparam logic [15:0] ALARM_BACKUP = 16'h0810;
  localparam logic [15:0] TORQUE_FULL  = 16'h2710;
  // Timing: clock rate, blink rates in millihertz, display alternation in ms.
  localparam longint CLK_HZ    = 25_000_000;
  localparam longint BLINK_SLOW_MHZ = 370;
  localparam longint BLINK_MID_MHZ  = 750;
  localparam longint BLINK_FAST_MHZ = 1500;
  localparam longint ALT_MS    = 500;
  localparam int HALF_SLOW = int'(CLK_HZ * 1000 / (2 * BLINK_SLOW_MHZ));
  localparam int HALF_MID  = int'(CLK_HZ * 1000 / (2 * BLINK_MID_MHZ));
  localparam int HALF_FAST = int'(CLK_HZ * 1000 / (2 * BLINK_FAST_MHZ));
  localparam int ALT_CYC   = int'(CLK_HZ * ALT_MS / 1000);
  // Segment patterns, bit 0 is segment a.
  localparam logic [6:0] SEG_SERVO_OFF = 7'h40;
  localparam logic [6:0] SEG_SERVO_ON  = 7'h01;
  localparam logic [6:0] SEG_FWD_OT    = 7'h5C;
  localparam logic [6:0] SEG_REV_OT    = 7'h63;
  localparam logic [6:0] SEG_ALARM     = 7'h77;
  localparam logic [6:0] SEG_BLANK     = 7'h00;
  localparam logic [15:0][6:0] SEG_HEX = {7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77, 7'h6F, 7'h7F,
                                          7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};
endpackage : servo_node_pkg
`default_nettype wire

/* File: ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Network controller model: it issues one cyclic demand per call, flagged by a one-cycle strobe.
module ctrl_model (
  input  wire logic        clk,
  output logic             cyclic_strobe,
  output logic      [15:0] torque_demand,
  output logic             amp_enable_demand
);
  // The demand stands with the strobe and is held afterwards, so every drive sees the same values.
  task automatic send(input logic [15:0] t, input logic en);
    @(posedge clk);
    cyclic_strobe     <= 1'b1;
    torque_demand     <= t;
    amp_enable_demand <= en;
    @(posedge clk);
    cyclic_strobe <= 1'b0;
  endtask : send
  // Idle with no demand pending.
  initial begin
    cyclic_strobe     = 1'b0;
    torque_demand     = 16'h0000;
    amp_enable_demand = 1'b0;
  end
endmodule : ctrl_model
`default_nettype wire

/* File: servo_node_cyclic_status_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module servo_node_cyclic_status_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rpt_on, strobe, amp_en, comm, enc_ok, volt_ok;
  logic pwm_off, hw_en, al_ev, al_clr, rpt_led, rcv_led, servo_en, fault, mt_clr, dyn_brk, wr_ev, fwd_ot, rev_ot;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos, rpos, rd;
  logic [3:0]  sel1, sel2;
  logic [1:0]  link, link_led;
  logic [2:0]  net;
  logic [15:0] tdem, tref, mt, acode, tcmd, echo, rmt, wcode;
  logic [6:0]  seg, stat;
  logic        er;
  int          n_mismatch, n_compared, cycles;
  ctrl_model u_ctrl_model (.clk(clk), .cyclic_strobe(strobe), .torque_demand(tdem), .amp_enable_demand(amp_en));
  servo_node_cyclic_status #(.HALF_SLOW(5), .HALF_MID(3), .HALF_FAST(2), .ALT_CYC(4)) u_servo_node_cyclic_status (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_rotary_selector(sel1),
    .second_rotary_selector(sel2), .link_up(link), .net_state(net), .repeater_on(rpt_on), .cyclic_strobe(strobe),
    .torque_demand(tdem), .amp_enable_demand(amp_en), .comm_active(comm), .encoder_sync_ok(enc_ok),
    .motor_voltage_ok(volt_ok), .pwm_off(pwm_off), .dynamic_brake(dyn_brk), .hw_enable(hw_en),
    .torque_reference(tref), .position_in(pos), .multiturn_in(mt), .alarm_event(al_ev), .alarm_code(acode),
    .alarm_clearable(al_clr), .warning_event(wr_ev), .warning_code(wcode), .forward_overtravel(fwd_ot),
    .reverse_overtravel(rev_ot), .link_indicator(link_led), .repeater_indicator(rpt_led),
    .receive_indicator(rcv_led), .segment(seg), .torque_command(tcmd), .servo_enable(servo_en),
    .fault_line(fault), .multiturn_clear(mt_clr), .resp_status(stat), .resp_position(rpos),
    .resp_torque_echo(echo), .resp_multiturn(rmt));
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and value comparison.
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is sampled high, so no wait count is assumed.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Service command write followed by the result read.
  task automatic svc(input logic [31:0] c);
    apb(servo_node_pkg::ADDR_SVC, 1'b1, c);
    apb(servo_node_pkg::ADDR_RES, 1'b0, 32'h0);
  endtask : svc
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_id;
    chk("segment", 32'h0000_0040, {25'h0, seg});
    apb(servo_node_pkg::ADDR_TLIM, 1'b0, 32'h0);
    chk("tlim", 32'h0000_2710, rd);
    apb(servo_node_pkg::ADDR_ID, 1'b0, 32'h0);
    chk("id", 32'h9A00_0000, rd);
    {sel1, sel2} <= 8'h5F;
    apb(servo_node_pkg::ADDR_ID, 1'b0, 32'h0);
    chk("id re-read", 32'h5F00_0000, rd);
    apb(8'h1C, 1'b0, 32'h0);
    chk("unmapped err", 32'h0000_0001, {31'h0, er});
  endtask : t_reset_id
  // Status flags and echo are checked on later cycles, since the echo lags the demand by one cycle.
  task automatic t_cyclic;
    {comm, enc_ok, volt_ok, hw_en, pos, mt} <= {4'hF, 32'h8765_4321, 16'h1234};
    u_ctrl_model.send(16'h2710, 1'b1);
    wait_cyc(2);
    chk("torque cmd", 32'h0000_2710, {16'h0, tcmd});
    chk("servo en", 32'h0000_0001, {31'h0, servo_en});
    u_ctrl_model.send(16'h0100, 1'b1);
    wait_cyc(1);
    chk("status", 32'h0000_000F, {25'h0, stat});
    chk("echo", 32'h0000_2710, {16'h0, echo});
    chk("position", 32'h8765_4321, rpos);
    chk("multiturn", 32'h0000_1234, {16'h0, rmt});
    pwm_off <= 1'b1;
    u_ctrl_model.send(16'h0100, 1'b1);
    wait_cyc(1);
    chk("status pwm off", 32'h0000_0007, {25'h0, stat});
    pwm_off <= 1'b0;
    tref <= 16'h00C8;
    apb(servo_node_pkg::ADDR_TLIM, 1'b1, 32'h0000_0064);
    u_ctrl_model.send(16'h0100, 1'b1);
    wait_cyc(1);
    chk("status limit", 32'h0000_001F, {25'h0, stat});
  endtask : t_cyclic
  task automatic t_alarm;
    {al_ev, al_clr, acode} <= {2'b11, 16'h0123};
    @(posedge clk);
    al_ev <= 1'b0;
    wait_cyc(2);
    chk("fault", 32'h0000_0001, {31'h0, fault});
    svc(32'h0000_2100);
    chk("alarm count", 32'h0001_0001, rd);
    svc(32'h0000_2000);
    chk("alarm code", 32'h0001_0123, rd);
    svc(32'h0000_2200);
    chk("unsupported", 32'h0003_0000, rd);
    apb(servo_node_pkg::ADDR_SVC, 1'b1, 32'h0000_3200);
    wait_cyc(4);
    chk("fault cleared", 32'h0, {31'h0, fault});
    chk("servo re-enabled", 32'h1, {31'h0, servo_en});
    {wr_ev, wcode} <= {1'b1, 16'h0456};
    @(posedge clk);
    wr_ev <= 1'b0;
    svc(32'h0000_2300);
    chk("warning code", 32'h0001_0456, rd);
    apb(servo_node_pkg::ADDR_SVC, 1'b1, 32'h0000_3500);
    svc(32'h0000_2400);
    chk("warning count", 32'h0001_0000, rd);
    svc(32'h0000_2600);
    chk("multiturn read", 32'h0001_1234, rd);
    apb(servo_node_pkg::ADDR_SVC, 1'b1, 32'h0000_3700);
    wait_cyc(1);
    chk("multiturn clear", 32'h1, {31'h0, mt_clr});
    dyn_brk <= 1'b1;
    wait_cyc(2);
    chk("servo braked", 32'h0, {31'h0, servo_en});
  endtask : t_alarm
  task automatic t_leds;
    {link, net, rpt_on} <= {2'b01, 3'h3, 1'b1};
    wait_cyc(2);
    chk("link", 32'h1, {30'h0, link_led});
    chk("rpt rcv sync", 32'h3, {30'h0, rpt_led, rcv_led});
    net <= 3'h0;
    wait_cyc(2);
    chk("rpt rcv idle", 32'h0, {30'h0, rpt_led, rcv_led});
  endtask : t_leds
  // Overtravel alternates pattern and blank, so eight samples must see both.
  task automatic t_ot(input logic fwd, input logic [6:0] pat);
    logic [6:0] any_on, all_on;
    {fwd_ot, rev_ot} <= {fwd, !fwd};
    {any_on, all_on} = 14'h007F;
    wait_cyc(2);
    repeat (8) begin
      @(posedge clk);
      any_on |= seg;
      all_on &= seg;
    end
    chk("overtravel seg", {16'h0, 1'b0, pat, 8'h00}, {16'h0, 1'b0, any_on, 1'b0, all_on});
  endtask : t_ot
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and main sequence.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, link, net, rpt_on} = {1'b1, 49'h0};
    {comm, enc_ok, volt_ok, pwm_off, hw_en, al_ev, al_clr, tref, pos, mt, acode} = 0;
    {dyn_brk, wr_ev, fwd_ot, rev_ot, wcode} = 0;
    {sel1, sel2} = 8'h9A;
    wait_cyc(4);
    rst <= 1'b0;
    wait_cyc(2);
    t_reset_id();
    t_cyclic();
    t_alarm();
    t_leds();
    t_ot(1'b1, servo_node_pkg::SEG_FWD_OT);
    t_ot(1'b0, servo_node_pkg::SEG_REV_OT);
    stop_test();
  end
endmodule : servo_node_cyclic_status_tb
`default_nettype wire
